/* File: src/dsp_core_control_bits.sv */
// dsp core control register with overrides, debounce and safeload engine
`include "dsp_ctrl_cfg.svh"
module dsp_core_control_bits #(
    parameter int DEB_CODE0_CYC = `DEB_CODE0_MS * `CLK_KHZ,
    parameter int DEB_CODE1_CYC = `DEB_CODE1_MS * `CLK_KHZ,
    parameter int DEB_CODE2_CYC = `DEB_CODE2_MS * `CLK_KHZ,
    parameter int DEB_CODE3_CYC = `DEB_CODE3_MS * `CLK_KHZ
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire dsp_ctrl_pkg::cp_req_t cp_i,
    output logic [`SL_DATA_W-1:0] cp_rdata_o,
    output logic cp_rvalid_o,
    input wire logic [`GPIO_N-1:0] gpio_i,
    input wire dsp_ctrl_pkg::aux_in_t aux_i,
    input wire dsp_ctrl_pkg::dsp_if_t dsp_if_i,
    input wire logic core_free_i,
    output dsp_ctrl_pkg::param_wr_t param_o,
    output logic [15:0] pin_set_o,
    output logic [`AUX_REGS-1:0][`AUX_W-1:0] aux_o,
    output logic [`IF_REGS-1:0][15:0] if_regs_o,
    output logic adc_mute_n_o
);
    import dsp_ctrl_pkg::*;

    localparam int FRAME_CYC = `FRAME_CYC;

    core_state_t st_r;
    core_state_t st_nxt;
    logic [`SL_WORD_W-1:0] mem_rd;
    logic mem_wr;
    logic [2:0] mem_wr_idx;
    logic [`SL_WORD_W-1:0] mem_mask;
    logic sl_issue;

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function automatic logic [`DEB_CNT_W-1:0] deb_limit(input logic [1:0] sel);
        case (sel)
            2'h0: deb_limit = `DEB_CNT_W'(DEB_CODE0_CYC - 1);
            2'h1: deb_limit = `DEB_CNT_W'(DEB_CODE1_CYC - 1);
            2'h2: deb_limit = `DEB_CNT_W'(DEB_CODE2_CYC - 1);
            default: deb_limit = `DEB_CNT_W'(DEB_CODE3_CYC - 1);
        endcase
    endfunction : deb_limit

    function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
                                      input int n);
        in_range = (a >= base) && (a < 12'(base + n));
    endfunction : in_range

    function automatic ctrl_t ctrl_from_word(input logic [15:0] w);
        ctrl_from_word.deb_sel = w[`DEB_SEL_LSB +: 2];
        ctrl_from_word.aux_ovr = w[`AUX_OVR_BIT];
        ctrl_from_word.pin_ovr = w[`PIN_OVR_BIT];
        ctrl_from_word.if_ovr = w[`IF_OVR_BIT];
        ctrl_from_word.sl_trig = w[`SL_TRIG_BIT];
        ctrl_from_word.adc_mute_n = w[`ADC_MUTE_N_BIT];
    endfunction : ctrl_from_word

    function automatic logic [15:0] ctrl_to_word(input ctrl_t c);
        ctrl_to_word = 16'h0000;
        ctrl_to_word[`DEB_SEL_LSB +: 2] = c.deb_sel;
        ctrl_to_word[`AUX_OVR_BIT] = c.aux_ovr;
        ctrl_to_word[`PIN_OVR_BIT] = c.pin_ovr;
        ctrl_to_word[`IF_OVR_BIT] = c.if_ovr;
        ctrl_to_word[`SL_TRIG_BIT] = c.sl_trig;
        ctrl_to_word[`ADC_MUTE_N_BIT] = c.adc_mute_n;
    endfunction : ctrl_to_word

    function automatic logic [2:0] first_set(input logic [`SL_PAIRS-1:0] v);
        first_set = 3'h0;
        for (int k = `SL_PAIRS - 1; k >= 0; k--)
        begin
            if (v[k])
                first_set = 3'(k);
        end
    endfunction : first_set

    // ****************************************************************
    // safeload pair storage
    // ****************************************************************
    // both halves of a pair share a word so one read feeds the transfer
    assign mem_wr = cp_i.wr && (in_range(cp_i.addr, `SL_DATA_BASE_ADDR, `SL_PAIRS)
                             || in_range(cp_i.addr, `SL_ADDR_BASE_ADDR, `SL_PAIRS));
    assign mem_wr_idx = in_range(cp_i.addr, `SL_DATA_BASE_ADDR, `SL_PAIRS)
                      ? 3'(cp_i.addr - `SL_DATA_BASE_ADDR)
                      : 3'(cp_i.addr - `SL_ADDR_BASE_ADDR);
    assign mem_mask = in_range(cp_i.addr, `SL_DATA_BASE_ADDR, `SL_PAIRS)
                    ? {{`SL_ADDR_W{1'b0}}, {`SL_DATA_W{1'b1}}}
                    : {{`SL_ADDR_W{1'b1}}, {`SL_DATA_W{1'b0}}};

    sl_pair_mem u_mem (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .wr_en_i(mem_wr), // [R10]
        .wr_idx_i(mem_wr_idx),
        .wr_mask_i(mem_mask),
        .wr_data_i({cp_i.wdata[`SL_ADDR_W-1:0], cp_i.wdata}),
        .rd_en_i(st_r.sl_state == SL_SCAN),
        .rd_idx_i(first_set(st_r.pending)),
        .rd_data_o(mem_rd)
    );

    // a pair leaves only on a free core slot, one pair per slot
    assign sl_issue = ce_i && (st_r.sl_state == SL_ISSUE) && core_free_i;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        logic [`DEB_CNT_W-1:0] lim;
        lim = deb_limit(st_r.ctrl.deb_sel); // [R1]
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;

        // debounce: a level must hold the whole interval to be taken
        for (int i = 0; i < `GPIO_N; i++)
        begin
            if (gpio_i[i] == st_r.deb_stable[i])
                st_nxt.deb_cnt[i] = '0;
            else if (st_r.deb_cnt[i] >= lim)
            begin
                st_nxt.deb_stable[i] = gpio_i[i]; // [R1]
                st_nxt.deb_cnt[i] = '0;
            end
            else
                st_nxt.deb_cnt[i] = `DEB_CNT_W'(st_r.deb_cnt[i] + 1'b1);
        end

        // pin setting register: pins own it unless overridden
        if (!st_r.ctrl.pin_ovr)
            st_nxt.pin_set = {12'h000, st_r.deb_stable}; // [R5]
        else if (cp_i.wr && cp_i.addr == `PIN_SET_ADDR)
            st_nxt.pin_set = cp_i.wdata[15:0]; // [R4]

        // aux converter registers
        for (int i = 0; i < `AUX_REGS; i++)
        begin
            if (!st_r.ctrl.aux_ovr && aux_i.valid[i])
                st_nxt.aux[i] = aux_i.data[i]; // [R3]
            else if (st_r.ctrl.aux_ovr && cp_i.wr && cp_i.addr == 12'(`AUX_BASE_ADDR + i))
                st_nxt.aux[i] = cp_i.wdata[`AUX_W-1:0]; // [R2]
        end

        // interface registers: program writes are dropped in override
        if (st_r.ctrl.if_ovr)
        begin
            if (cp_i.wr && in_range(cp_i.addr, `IF_BASE_ADDR, `IF_REGS))
                st_nxt.ifr[3'(cp_i.addr - `IF_BASE_ADDR)] = cp_i.wdata[15:0]; // [R6]
        end
        else if (dsp_if_i.wr)
            st_nxt.ifr[dsp_if_i.idx] = dsp_if_i.data; // [R7]

        // safeload sequencer
        case (st_r.sl_state)
            SL_IDLE:
            begin
                if (st_r.ctrl.sl_trig)
                    st_nxt.sl_state = SL_SCAN; // [R8]
            end
            SL_SCAN:
            begin
                if (st_r.pending == '0)
                begin
                    st_nxt.ctrl.sl_trig = 1'b0; // [R9]
                    st_nxt.sl_state = SL_IDLE;
                end
                else
                begin
                    st_nxt.sl_idx = first_set(st_r.pending); // [R11]
                    st_nxt.sl_state = SL_ISSUE;
                end
            end
            SL_ISSUE:
            begin
                if (core_free_i)
                begin
                    st_nxt.pending[st_r.sl_idx] = 1'b0; // [R11]
                    st_nxt.sl_state = SL_SCAN;
                end
            end
            default: st_nxt.sl_state = SL_IDLE;
        endcase

        // a fresh write marks the pair; placed last so set beats clear
        if (mem_wr)
            st_nxt.pending[mem_wr_idx] = 1'b1; // [R11]

        // control register write; trigger only ever set from the port
        if (cp_i.wr && cp_i.addr == `CORE_CTRL_ADDR)
        begin
            st_nxt.ctrl.deb_sel = cp_i.wdata[`DEB_SEL_LSB +: 2];
            st_nxt.ctrl.aux_ovr = cp_i.wdata[`AUX_OVR_BIT];
            st_nxt.ctrl.pin_ovr = cp_i.wdata[`PIN_OVR_BIT];
            st_nxt.ctrl.if_ovr = cp_i.wdata[`IF_OVR_BIT];
            st_nxt.ctrl.adc_mute_n = cp_i.wdata[`ADC_MUTE_N_BIT]; // [R12]
            if (cp_i.wdata[`SL_TRIG_BIT])
                st_nxt.ctrl.sl_trig = 1'b1; // [R8]
        end

        // reads; safeload pairs are write-only and read zero
        if (cp_i.rd)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = '0;
            if (cp_i.addr == `CORE_CTRL_ADDR)
                st_nxt.rdata[15:0] = ctrl_to_word(st_r.ctrl); // [R9]
            else if (cp_i.addr == `PIN_SET_ADDR)
                st_nxt.rdata[15:0] = st_r.pin_set;
            else if (in_range(cp_i.addr, `AUX_BASE_ADDR, `AUX_REGS))
                st_nxt.rdata[`AUX_W-1:0] = st_r.aux[2'(cp_i.addr - `AUX_BASE_ADDR)];
            else if (in_range(cp_i.addr, `IF_BASE_ADDR, `IF_REGS))
                st_nxt.rdata[15:0] = st_r.ifr[3'(cp_i.addr - `IF_BASE_ADDR)];
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            st_r <= '0;
            st_r.ctrl <= ctrl_from_word(`CORE_CTRL_RST); // [R15] [R12]
        end
        else if (ce_i)
            st_r <= st_nxt;
    end

    assign cp_rdata_o = st_r.rdata;
    assign cp_rvalid_o = st_r.rvalid;
    assign pin_set_o = st_r.pin_set;
    assign aux_o = st_r.aux;
    assign if_regs_o = st_r.ifr;
    assign adc_mute_n_o = st_r.ctrl.adc_mute_n;
    assign param_o.wr = sl_issue;
    assign param_o.addr = mem_rd[`SL_WORD_W-1:`SL_DATA_W];
    assign param_o.data = mem_rd[`SL_DATA_W-1:0];

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [10:0] sl_wait;

    // counts cycles a safeload has been outstanding
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || !st_r.ctrl.sl_trig)
            sl_wait <= '0;
        else if (ce_i && sl_wait != 11'h7ff)
            sl_wait <= 11'(sl_wait + 1'b1);
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    AST_DEB_TAKE: assert property (ce_i && gpio_i[0] != st_r.deb_stable[0] // [R1]
        && st_r.deb_cnt[0] == deb_limit(st_r.ctrl.deb_sel)
        |=> st_r.deb_stable[0] == $past(gpio_i[0]))
        else $error("debounced level not taken at interval end");
    AST_AUX_CP: assert property (ce_i && st_r.ctrl.aux_ovr && cp_i.wr // [R2]
        && cp_i.addr == `AUX_BASE_ADDR |=> aux_o[0] == $past(cp_i.wdata[`AUX_W-1:0]))
        else $error("aux write ignored in override");
    AST_AUX_HOLD: assert property (st_r.ctrl.aux_ovr && !cp_i.wr // [R3]
        |=> $stable(aux_o))
        else $error("aux register moved under override");
    AST_PIN_CP: assert property (ce_i && st_r.ctrl.pin_ovr && cp_i.wr // [R4]
        && cp_i.addr == `PIN_SET_ADDR |=> pin_set_o == $past(cp_i.wdata[15:0]))
        else $error("pin setting write ignored in override");
    AST_PIN_HOLD: assert property (st_r.ctrl.pin_ovr && !cp_i.wr // [R5]
        |=> $stable(pin_set_o))
        else $error("pin setting loaded from pins under override");
    AST_IF_CP: assert property (ce_i && st_r.ctrl.if_ovr && cp_i.wr // [R6]
        && cp_i.addr == `IF_BASE_ADDR |=> if_regs_o[0] == $past(cp_i.wdata[15:0]))
        else $error("interface write ignored in override");
    AST_IF_HOLD: assert property (st_r.ctrl.if_ovr && !cp_i.wr // [R7]
        |=> $stable(if_regs_o))
        else $error("program changed interface register under override");
    AST_TRIG_SET: assert property (ce_i && cp_i.wr && cp_i.addr == `CORE_CTRL_ADDR // [R8]
        && cp_i.wdata[`SL_TRIG_BIT] |=> st_r.ctrl.sl_trig ##1 st_r.sl_state != SL_IDLE)
        else $error("safeload trigger did not start transfer");
    AST_TRIG_DONE: assert property (ce_i && st_r.sl_state == SL_SCAN // [R9]
        && st_r.pending == '0 && !cp_i.wr |=> !st_r.ctrl.sl_trig)
        else $error("trigger not cleared after transfer");
    AST_PEND_CLR: assert property (param_o.wr && !mem_wr // [R11]
        |=> st_r.pending[$past(st_r.sl_idx)] == 1'b0)
        else $error("pending pair not cleared after issue");
    AST_SKIP: assert property (param_o.wr // [R11]
        |-> $past(st_r.pending[st_r.sl_idx], 2) || st_r.pending[st_r.sl_idx])
        else $error("unwritten pair transferred");
    AST_MUTE_RST: assert property ($rose(nrst_i) |-> adc_mute_n_o == 1'b0 // [R12] [R15]
        && !st_r.ctrl.aux_ovr && !st_r.ctrl.sl_trig && st_r.ctrl.deb_sel == 2'h0)
        else $error("control bits not zero after reset");
    AST_FRAME: assert property (core_free_i && ce_i |-> sl_wait < FRAME_CYC) // [R13] [R14]
        else $error("safeload outlasted one frame");

    CVR_SAFELOAD: cover property ($fell(st_r.ctrl.sl_trig) && $past(st_r.pending) == '0);
    CVR_TWO_PAIRS: cover property (param_o.wr ##[1:8] param_o.wr);
    CVR_AUX_OVR: cover property (st_r.ctrl.aux_ovr && cp_i.wr && aux_i.valid[0]);
    CVR_DEBOUNCE: cover property ($changed(st_r.deb_stable[0]));

endmodule : dsp_core_control_bits

/* File: src/dsp_ctrl_cfg.svh */
// constants for the dsp core control register block
// Operation
// R1 - debounce field picks 20, 40, 10 or 5 ms for codes 00..11
// R2 - aux override set lets the control port write aux registers 2057..2060
// R3 - aux override set stops pin inputs updating the aux registers
// R4 - pin-setting override set lets the control port write register 2056
// R5 - pin-setting override set stops pin levels loading register 2056
// R6 - interface override set lets the control port write registers 2048..2055
// R7 - interface override set blocks the dsp program updating interface registers
// R8 - writing 1 to the safeload trigger starts the safeload transfer
// R9 - trigger bit clears itself when the transfer is done
// R10 - five safeload address/data pairs feed the transfer
// R11 - only pairs written since last safeload go out, then their pending clears
// R12 - adc mute is active low and resets to 0, muting the adcs
// R13 - a triggered safeload finishes within one frame, about 21 us
// R14 - software keeps programs to 1019 cycles so free slots exist
// R15 - all control bits reset to zero
`ifndef DSP_CTRL_CFG_SVH
`define DSP_CTRL_CFG_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define IF_BASE_ADDR 12'h800
`define IF_REGS 8
`define PIN_SET_ADDR 12'h808
`define AUX_BASE_ADDR 12'h809
`define AUX_REGS 4
`define SL_DATA_BASE_ADDR 12'h810
`define SL_ADDR_BASE_ADDR 12'h815
`define SL_PAIRS 5
`define CORE_CTRL_ADDR 12'h81c

// ****************************************************************
// core control field positions and reset value
// ****************************************************************
`define DEB_SEL_LSB 12
`define AUX_OVR_BIT 8
`define PIN_OVR_BIT 7
`define IF_OVR_BIT 6
`define SL_TRIG_BIT 5
`define ADC_MUTE_N_BIT 4
`define CORE_CTRL_RST 16'h0000

// ****************************************************************
// widths and timing
// ****************************************************************
`define GPIO_N 4
`define AUX_W 12
`define SL_ADDR_W 12
`define SL_DATA_W 40
`define SL_WORD_W 52
`define DEB_CNT_W 22
`define CLK_KHZ 50000
`define DEB_CODE0_MS 20
`define DEB_CODE1_MS 40
`define DEB_CODE2_MS 10
`define DEB_CODE3_MS 5
`define FRAME_US 21
`define FRAME_CYC (`FRAME_US * `CLK_KHZ / 1000)

`endif

/* File: src/dsp_ctrl_pkg.sv */
// types shared by the dsp core control block
`include "dsp_ctrl_cfg.svh"

package dsp_ctrl_pkg;

    // control port request, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [`SL_DATA_W-1:0] wdata;
    } cp_req_t;

    // converter samples arriving from the multipurpose pins
    typedef struct packed {
        logic [`AUX_REGS-1:0] valid;
        logic [`AUX_REGS-1:0][`AUX_W-1:0] data;
    } aux_in_t;

    // interface register update from the running program
    typedef struct packed {
        logic wr;
        logic [2:0] idx;
        logic [15:0] data;
    } dsp_if_t;

    // parameter ram write toward the core
    typedef struct packed {
        logic wr;
        logic [`SL_ADDR_W-1:0] addr;
        logic [`SL_DATA_W-1:0] data;
    } param_wr_t;

    typedef enum logic [1:0] {SL_IDLE, SL_SCAN, SL_ISSUE} sl_state_t;

    typedef struct packed {
        logic [1:0] deb_sel;
        logic aux_ovr;
        logic pin_ovr;
        logic if_ovr;
        logic sl_trig;
        logic adc_mute_n;
    } ctrl_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [15:0] pin_set;
        logic [`GPIO_N-1:0] deb_stable;
        logic [`GPIO_N-1:0][`DEB_CNT_W-1:0] deb_cnt;
        logic [`AUX_REGS-1:0][`AUX_W-1:0] aux;
        logic [`IF_REGS-1:0][15:0] ifr;
        logic [`SL_PAIRS-1:0] pending;
        logic [2:0] sl_idx;
        sl_state_t sl_state;
        logic [`SL_DATA_W-1:0] rdata;
        logic rvalid;
    } core_state_t;

    typedef struct packed {
        logic [`SL_PAIRS-1:0][`SL_WORD_W-1:0] words;
        logic [`SL_WORD_W-1:0] rd;
    } mem_state_t;

endpackage : dsp_ctrl_pkg

/* File: src/sl_pair_mem.sv */
// storage for the five safeload address/data pairs
`include "dsp_ctrl_cfg.svh"
module sl_pair_mem (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [`SL_WORD_W-1:0] wr_mask_i,
    input wire logic [`SL_WORD_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [2:0] rd_idx_i,
    output logic [`SL_WORD_W-1:0] rd_data_o
);
    import dsp_ctrl_pkg::*;

    mem_state_t st_r;
    mem_state_t st_nxt;

    // masked write lets address and data halves be written apart
    always_comb
    begin
        st_nxt = st_r;
        if (wr_en_i && wr_idx_i < 3'(`SL_PAIRS))
        begin
            st_nxt.words[wr_idx_i] = (st_r.words[wr_idx_i] & ~wr_mask_i)
                                   | (wr_data_i & wr_mask_i);
        end
        if (rd_en_i && rd_idx_i < 3'(`SL_PAIRS))
        begin
            st_nxt.rd = st_r.words[rd_idx_i]; // read sees the old word
        end
    end

    // pairs power up as zero, matching their defaults
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            st_r <= '0;
        else if (ce_i)
            st_r <= st_nxt;
    end

    assign rd_data_o = st_r.rd;

endmodule : sl_pair_mem

/* File: test/tb.sv */
// self-checking testbench for the dsp core control register block
`include "dsp_ctrl_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsp_ctrl_pkg::*;

    // ****************************************************************
    // signals and design instance
    // ****************************************************************
    // short debounce counts keep the run small
    localparam int D0 = 8;
    localparam int D1 = 16;
    localparam int D2 = 4;
    localparam int D3 = 2;
    localparam logic [11:0] CTRL = `CORE_CTRL_ADDR;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic core_free_i = 1'b1;
    cp_req_t cp = '0;
    logic [3:0] gpio = 4'h0;
    aux_in_t aux = '0;
    dsp_if_t dif = '0;
    logic [39:0] rdata;
    logic rvalid;
    param_wr_t prm;
    logic [15:0] pin;
    logic [3:0][11:0] auxo;
    logic [7:0][15:0] ifo;
    logic mute_n;
    int n_fail = 0;
    int n_tests = 0;
    param_wr_t got[$];

    dsp_core_control_bits #(
        .DEB_CODE0_CYC(D0),
        .DEB_CODE1_CYC(D1),
        .DEB_CODE2_CYC(D2),
        .DEB_CODE3_CYC(D3)
    ) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .cp_i(cp),
        .cp_rdata_o(rdata), .cp_rvalid_o(rvalid), .gpio_i(gpio), .aux_i(aux),
        .dsp_if_i(dif), .core_free_i(core_free_i), .param_o(prm),
        .pin_set_o(pin), .aux_o(auxo), .if_regs_o(ifo), .adc_mute_n_o(mute_n)
    );

    always #10 clock_i = ~clock_i;

    // param_o.wr is a combinational pulse, so it is captured at the edge
    always @(posedge clock_i)
        if (prm.wr === 1'b1)
            got.push_back(prm);

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [39:0] d);
        @(posedge clock_i);
        cp.wr <= 1'b1;
        cp.addr <= a;
        cp.wdata <= d;
        @(posedge clock_i);
        cp.wr <= 1'b0;
    endtask : wr

    // read data is registered on the same edge that takes the request
    task automatic rd(input logic [11:0] a, output logic [39:0] d);
        @(posedge clock_i);
        cp.rd <= 1'b1;
        cp.addr <= a;
        @(posedge clock_i);
        cp.rd <= 1'b0;
        #1;
        chk(rvalid, 1'b1, "read strobe");
        d = rdata;
    endtask : rd

    task automatic complete_run;
        $display("checks %0d errors %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        logic [39:0] d;
        rd(CTRL, d);
        chk(d, 40'h0, "control reset");
        chk(mute_n, 1'b0, "adc muted");
        chk({pin, auxo}, '0, "pin and aux reset");
        chk(ifo[3:0], '0, "interface low reset");
        chk(ifo[7:4], '0, "interface high reset");
        rd(12'h81d, d);
        chk(d, 40'h0, "unmapped read");
        wr(CTRL, 40'h0010);
        tick(1);
        chk(mute_n, 1'b1, "adc unmuted");
    endtask : t_reset

    task automatic t_debounce;
        int n [4] = '{D0, D1, D2, D3};
        int k;
        logic [15:0] keep;
        for (int c = 0; c < 4; c++)
        begin
            wr(CTRL, 40'h0010 | (40'(c) << `DEB_SEL_LSB));
            gpio <= ~gpio;
            k = 0;
            // the new level is only seen from the next edge on
            tick(1);
            while (pin[3:0] !== gpio && k < 40)
            begin
                tick(1);
                k++;
            end
            chk(k >= n[c] && k <= n[c] + 2, 1'b1, "debounce length");
        end
        // pin override on: the debounced level must not reach the register
        keep = pin;
        wr(CTRL, 40'h0090);
        gpio <= ~gpio;
        tick(40);
        chk(pin, keep, "pin load blocked");
    endtask : t_debounce

    task automatic t_override;
        // overrides off: control-port writes are dropped
        wr(CTRL, 40'h0010);
        wr(`AUX_BASE_ADDR + 12'd3, 40'habc);
        wr(`PIN_SET_ADDR, 40'h5a5a);
        wr(`IF_BASE_ADDR + 12'd7, 40'hc3c3);
        tick(1);
        chk({auxo[3], pin[15:4], ifo[7]}, '0, "writes refused");
        wr(CTRL, 40'h01d0);
        wr(`AUX_BASE_ADDR + 12'd3, 40'habc);
        wr(`PIN_SET_ADDR, 40'h5a5a);
        wr(`IF_BASE_ADDR + 12'd7, 40'hc3c3);
        tick(1);
        chk(auxo[3], 12'habc, "aux write");
        chk(pin, 16'h5a5a, "pin write");
        chk(ifo[7], 16'hc3c3, "if write");
        // sources fire while overrides hold; stored values must survive
        @(posedge clock_i);
        aux.valid <= 4'hf;
        aux.data <= {4{12'h123}};
        dif <= '{wr: 1'b1, idx: 3'd7, data: 16'h7777};
        @(posedge clock_i);
        aux.valid <= 4'h0;
        dif.wr <= 1'b0;
        tick(1);
        chk(auxo[3], 12'habc, "aux held");
        chk(ifo[7], 16'hc3c3, "if held");
        wr(CTRL, 40'h0010);
        @(posedge clock_i);
        aux.valid <= 4'h8;
        dif.wr <= 1'b1;
        @(posedge clock_i);
        aux.valid <= 4'h0;
        dif.wr <= 1'b0;
        tick(1);
        chk(auxo[3], 12'h123, "aux from pins");
        chk(ifo[7], 16'h7777, "if from program");
    endtask : t_override

    task automatic t_safeload;
        logic [39:0] d;
        int k;
        @(posedge clock_i);
        core_free_i <= 1'b0;
        wr(`SL_DATA_BASE_ADDR + 12'd1, 40'h12_3456_789a);
        wr(`SL_ADDR_BASE_ADDR + 12'd1, 40'h0a5);
        wr(`SL_DATA_BASE_ADDR + 12'd3, 40'hfe_dcba_9876);
        wr(`SL_ADDR_BASE_ADDR + 12'd3, 40'h3ff);
        got.delete();
        for (int p = 0; p < 2; p++)
        begin
            wr(CTRL, 40'h0030);
            rd(CTRL, d);
            chk(d, 40'h0030, "trigger set");
            chk(got.size(), 0, "stalled core");
            // free core slots stand in for a program that leaves room
            @(posedge clock_i);
            core_free_i <= 1'b1;
            k = 0;
            d[5] = 1'b1;
            while (d[5] !== 1'b0 && k < 1050)
            begin
                rd(CTRL, d);
                k += 3;
            end
            chk(d, 40'h0010, "trigger cleared");
            chk(got.size(), p == 0 ? 2 : 0, "pairs sent");
            if (p == 0 && got.size() == 2)
            begin
                chk({got[0].addr, got[0].data}, {12'h0a5, 40'h12_3456_789a}, "pair 1");
                chk({got[1].addr, got[1].data}, {12'h3ff, 40'hfe_dcba_9876}, "pair 3");
            end
            got.delete();
            @(posedge clock_i);
            core_free_i <= 1'b0;
        end
    endtask : t_safeload

    // a write presented while the enable is low must leave no trace
    task automatic t_freeze;
        @(posedge clock_i);
        ce_i <= 1'b0;
        cp <= '{wr: 1'b1, rd: 1'b0, addr: CTRL, wdata: 40'h0};
        @(posedge clock_i);
        cp.wr <= 1'b0;
        ce_i <= 1'b1;
        tick(1);
        chk(mute_n, 1'b1, "frozen write ignored");
    endtask : t_freeze

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_reset();
        t_debounce();
        t_override();
        t_safeload();
        t_freeze();
        complete_run();
    end

    // generous bound: the whole sequence needs under two hundred cycles
    initial
    begin
        #400us;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : tb
